//--- hw/rdqf_pkg.sv
//------------------------------------------------------------
//------------------------------------------------------------
package rdqf_pkg;
   // register byte offsets on the slave port
   localparam logic [7:0]  REG_BASE      = 8'h00;  // queue base pointer
   localparam logic [7:0]  REG_LEN       = 8'h04;  // queue length in bytes
   localparam logic [7:0]  REG_CUR       = 8'h08;  // current descriptor pointer
   localparam logic [7:0]  REG_ENQ       = 8'h0c;  // enqueue / available count
   localparam logic [7:0]  REG_CTRL      = 8'h10;  // bit 0 enables fetching
   localparam logic [7:0]  REG_STAT      = 8'h14;  // fetch engine state
   localparam logic [7:0]  REG_DROP      = 8'h18;  // discarded continuation buffers
   // descriptor second-word fields
   localparam int unsigned CONT_BIT      = 31;
   localparam int unsigned TAG_MSB       = 30;
   localparam int unsigned TAG_LSB       = 16;
   localparam int unsigned LEN_MSB       = 15;
   // sizes and strides
   localparam logic [31:0] DESC_BYTES    = 32'h8;
   localparam logic [31:0] WORD_BYTES    = 32'h4;
   localparam logic [2:0]  STORE_FULL    = 3'h4;   // internal descriptor slots
   localparam logic [2:0]  STORE_ROOM2   = 3'h2;   // level that still fits two
   localparam logic [6:0]  KB_LAST_PAIR  = 7'h7f;  // last 8-byte slot of a 1 KB page
   // ahb encodings
   localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
   localparam logic [2:0]  HBURST_SINGLE = 3'h0;
   localparam logic [2:0]  HBURST_INCR   = 3'h1;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;
   // reset values
   localparam logic [31:0] RST_WORD      = 32'h0;
   localparam logic [15:0] RST_COUNT     = 16'h0;

   // pointer after one descriptor, wrapping at base plus length
   function automatic logic [31:0] rdqf_next_ptr(input logic [31:0] cur,
                                                 input logic [31:0] base,
                                                 input logic [31:0] qLen);
      rdqf_next_ptr = ((cur + DESC_BYTES) >= (base + qLen)) ? base : cur + DESC_BYTES;
   endfunction
   // byte length field of a second word
   function automatic logic [15:0] rdqf_len(input logic [31:0] w);
      rdqf_len = w[LEN_MSB:0];
   endfunction
endpackage

//--- hw/rdqf_ahb_fetch.sv
`timescale 1ns/10ps
`default_nettype none
module rdqf_ahb_fetch import rdqf_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        start,     // one-cycle request, taken while idle
   input  wire logic [31:0] startAddr, // first word of the burst
   input  wire logic [2:0]  beats,     // words in the burst
   input  wire logic        mHready,
   input  wire logic [31:0] mHrdata,
   output logic      [31:0] mHaddr,
   output logic      [1:0]  mHtrans,
   output logic      [2:0]  mHburst,
   output logic      [2:0]  mHsize,
   output logic             mHwrite,
   output logic             busy,
   output logic             beatValid, // one-cycle pulse per read word
   output logic      [31:0] beatData
);
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0]  trans;
      logic [2:0]  burst;
      logic [2:0]  addrLeft;  // address phases still to issue
      logic [2:0]  dataLeft;  // data phases still to complete
      logic        dataPend;  // a data phase is on the bus
      logic        busy;
      logic        beatValid;
      logic [31:0] beatData;
   } rdqf_mst_t;
   rdqf_mst_t s, n;

   //------------------------------------------------------------
   // pipelined incrementing read burst
   //------------------------------------------------------------
   always_comb begin
      n           = s;
      n.beatValid = 1'h0;
      if (mHready) begin
         if (s.dataPend) begin
            n.beatValid = 1'h1;
            n.beatData  = mHrdata;
            n.dataLeft  = s.dataLeft - 3'h1;
            if (s.dataLeft == 3'h1) begin
               n.busy = 1'h0;
            end
         end
         n.dataPend = (s.trans != HTRANS_IDLE);
         if (s.trans != HTRANS_IDLE) begin
            n.addrLeft = s.addrLeft - 3'h1;
            if (s.addrLeft > 3'h1) begin
               n.addr  = s.addr + WORD_BYTES;
               n.trans = HTRANS_SEQ;
            end else begin
               n.trans = HTRANS_IDLE;
            end
         end
      end
      // the engine itself drives the bus, no host help needed
      if (start && !s.busy) begin
         n.busy     = 1'h1;
         n.addr     = startAddr;
         n.trans    = HTRANS_NONSEQ;
         n.burst    = HBURST_INCR;
         n.addrLeft = beats;
         n.dataLeft = beats;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '{addr: RST_WORD, trans: HTRANS_IDLE, burst: HBURST_SINGLE, addrLeft: 3'h0,
                dataLeft: 3'h0, dataPend: 1'h0, busy: 1'h0, beatValid: 1'h0, beatData: RST_WORD};
      end else begin
         s <= n;
      end
   end

   assign mHaddr    = s.addr;
   assign mHtrans   = s.trans;
   assign mHburst   = s.burst;
   assign mHsize    = HSIZE_WORD;
   assign mHwrite   = 1'h0;
   assign busy      = s.busy;
   assign beatValid = s.beatValid;
   assign beatData  = s.beatData;

   // a beat held in a wait state keeps its address; an accepted one steps by a word
   burst_incr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (mHtrans == HTRANS_SEQ) |-> (mHburst == HBURST_INCR &&
      mHaddr == ($past(mHready) ? $past(mHaddr) + WORD_BYTES : $past(mHaddr))))
      else $error("burst beat not incrementing");
   master_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (start && !s.busy) |=> (mHtrans == HTRANS_NONSEQ && mHaddr == $past(startAddr) && busy))
      else $error("fetch burst did not start");
endmodule // rdqf_ahb_fetch
`default_nettype wire

//--- hw/rdqf_desc_store.sv
`timescale 1ns/10ps
`default_nettype none
module rdqf_desc_store import rdqf_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        push,      // store one whole descriptor
   input  wire logic [63:0] pushData,  // second word high, pointer low
   input  wire logic        pop,       // drop the head entry
   output logic             headValid,
   output logic      [63:0] headData,
   output logic      [2:0]  level
);
   typedef struct packed {
      logic [3:0][63:0] mem;
      logic [1:0]       wp;
      logic [1:0]       rp;
      logic [2:0]       level;
   } rdqf_store_t;
   rdqf_store_t s, n;

   //------------------------------------------------------------
   // four-entry ring of fetched descriptors
   //------------------------------------------------------------
   always_comb begin
      n = s;
      // pushes beyond full are never issued: fetch checks room first
      if (push && s.level != STORE_FULL) begin
         n.mem[s.wp] = pushData;
         n.wp        = s.wp + 2'h1;
      end
      if (pop && s.level != 3'h0) begin
         n.rp = s.rp + 2'h1;
      end
      n.level = s.level + {2'h0, n.wp != s.wp} - {2'h0, n.rp != s.rp};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '{mem: '0, wp: 2'h0, rp: 2'h0, level: 3'h0};
      end else begin
         s <= n;
      end
   end

   assign headValid = (s.level != 3'h0);
   assign headData  = s.mem[s.rp];
   assign level     = s.level;

   store_full_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (push && level == STORE_FULL) |-> 1'h0)
      else $error("descriptor pushed into full store");
endmodule // rdqf_desc_store
`default_nettype wire

//--- hw/rdqf_rx_desc_fetch.sv
`timescale 1ns/10ps
`default_nettype none
module rdqf_rx_desc_fetch import rdqf_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // register slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // descriptor fetch master
   output logic      [31:0] mHaddr,
   output logic      [1:0]  mHtrans,
   output logic      [2:0]  mHburst,
   output logic      [2:0]  mHsize,
   output logic             mHwrite,
   input  wire logic        mHready,
   input  wire logic [31:0] mHrdata,
   // buffer consumer (receive data side)
   input  wire logic        frameOpen,   // a frame is in progress
   input  wire logic        descTake,    // consumer takes the offered buffer
   output logic             descValid,
   output logic      [31:0] descAddr,
   output logic      [15:0] descLen,
   output logic      [14:0] descTag,
   output logic             descCont,
   output logic      [14:0] activeTag    // tag of the buffer now in use
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      logic [31:0] base;       // free-buffer queue base
      logic [31:0] qLen;       // queue length, bytes
      logic [31:0] cur;        // next descriptor to fetch
      logic [15:0] avail;      // enqueued, not yet fetched
      logic        enable;     // fetch enable
      logic [15:0] dropCnt;    // discarded continuation buffers
      logic        sWrite;     // write data phase pending
      logic [7:0]  sAddr;      // its register offset
      logic        ready;      // slave ready, never stretched
      logic        resp;       // always okay
      logic [31:0] rdata;      // read data for the data phase
      logic [31:0] word0;      // first word of the landing descriptor
      logic        half;       // word0 holds a value
      logic [1:0]  pendDesc;   // descriptors of the burst in flight
      logic        outValid;   // offer stage
      logic [31:0] outAddr;
      logic [15:0] outLen;
      logic [14:0] outTag;
      logic        outCont;
      logic [14:0] activeTag;
   } rdqf_top_t;
   rdqf_top_t s, n;

   logic        aPhase;     // slave address phase taken
   logic        contDrop;   // offered buffer cannot start a frame
   logic        takeOk;     // consumer take honoured
   logic        fetchGo;    // start a descriptor burst
   logic [1:0]  fetchN;     // descriptors in that burst
   logic [7:0]  enqAdd;     // count written to the enqueue register
   logic        push;       // a full descriptor has landed
   logic        pop;        // store head leaves
   logic        mBusy;
   logic        beatValid;
   logic [31:0] beatData;
   logic        headValid;
   logic [63:0] headData;
   logic [2:0]  level;

   //------------------------------------------------------------
   // fetch decision
   //------------------------------------------------------------
   assign aPhase = hsel && htrans[1] && hready;
   // a two-descriptor burst must not wrap or cross a 1 KB page
   assign fetchN = (s.avail >= 16'h2 && level <= STORE_ROOM2 &&
                    rdqf_next_ptr(s.cur, s.base, s.qLen) == s.cur + DESC_BYTES &&
                    s.cur[9:3] != KB_LAST_PAIR) ? 2'h2 : 2'h1;
   // nothing is fetched while the count is empty; one burst at a time
   assign fetchGo = s.enable && s.avail != RST_COUNT && s.pendDesc == 2'h0 &&
                    !mBusy && level < STORE_FULL;

   //------------------------------------------------------------
   // offer stage filtering
   //------------------------------------------------------------
   // a continuation-only buffer with no frame open is thrown away
   assign contDrop = s.outValid && s.outCont && !frameOpen;
   // so a take of such a buffer only succeeds mid-frame
   assign takeOk   = descTake && s.outValid && !contDrop;

   //------------------------------------------------------------
   // next-state logic
   //------------------------------------------------------------
   always_comb begin
      n      = s;
      enqAdd = 8'h00;
      push   = 1'h0;
      pop    = 1'h0;
      // offer stage leaves
      if (contDrop) begin
         n.outValid = 1'h0;
         n.dropCnt  = s.dropCnt + 16'h1;
      end
      if (takeOk) begin
         n.outValid  = 1'h0;
         n.activeTag = s.outTag;
      end
      // store head moves forward
      if (headValid) begin
         if (rdqf_len(headData[63:32]) == 16'h0) begin
            pop = 1'h1;
         end else if (!s.outValid || takeOk || contDrop) begin
            pop        = 1'h1;
            n.outValid = 1'h1;
            n.outAddr  = headData[31:0];
            n.outLen   = rdqf_len(headData[63:32]);
            n.outTag   = headData[32+TAG_MSB:32+TAG_LSB];
            n.outCont  = headData[32+CONT_BIT];
         end
      end
      // descriptor words land in pairs, pointer first
      if (beatValid) begin
         if (!s.half) begin
            n.word0 = beatData;
            n.half  = 1'h1;
         end else begin
            push       = 1'h1;
            n.half     = 1'h0;
            n.pendDesc = s.pendDesc - 2'h1;
            // length is in bytes, so the end is base plus length
            n.cur      = rdqf_next_ptr(s.cur, s.base, s.qLen);
         end
      end
      if (fetchGo) begin
         n.pendDesc = fetchN;
      end
      // register writes in the data phase; a software write wins
      if (s.sWrite) begin
         case (s.sAddr)
            REG_BASE: begin
               n.base = hwdata;
            end
            REG_LEN: begin
               n.qLen = hwdata;
            end
            REG_CUR: begin
               n.cur = hwdata;
            end
            REG_ENQ: begin
               enqAdd = hwdata[7:0];
            end
            REG_CTRL: begin
               n.enable = hwdata[0];
            end
            default: begin
            end
         endcase
      end
      // count grows with enqueue writes and shrinks as bursts go out
      n.avail = s.avail + {8'h00, enqAdd}
                - (fetchGo ? {14'h0, fetchN} : RST_COUNT);
      // slave address phase
      n.sWrite = aPhase && hwrite;
      n.sAddr  = haddr[7:0];
      if (aPhase && !hwrite) begin
         // read sees this cycle's updates except for status and drop count, so write-then-read is coherent
         case (haddr[7:0])
            REG_BASE: begin
               n.rdata = n.base;
            end
            REG_LEN: begin
               n.rdata = n.qLen;
            end
            REG_CUR: begin
               n.rdata = n.cur;
            end
            REG_ENQ: begin
               n.rdata = {16'h0, n.avail};
            end
            REG_CTRL: begin
               n.rdata = {31'h0, n.enable};
            end
            REG_STAT: begin
               n.rdata = {24'h0, 1'h0, level, s.pendDesc, mBusy, s.outValid};
            end
            REG_DROP: begin
               n.rdata = {16'h0, s.dropCnt};
            end
            default: begin
               n.rdata = RST_WORD;   // unmapped reads return zero
            end
         endcase
      end
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '{base: RST_WORD, qLen: RST_WORD, cur: RST_WORD, avail: RST_COUNT, enable: 1'h0,
                dropCnt: RST_COUNT, sWrite: 1'h0, sAddr: 8'h00, ready: 1'h1, resp: 1'h0,
                rdata: RST_WORD, word0: RST_WORD, half: 1'h0, pendDesc: 2'h0, outValid: 1'h0,
                outAddr: RST_WORD, outLen: RST_COUNT, outTag: 15'h0, outCont: 1'h0,
                activeTag: 15'h0};
      end else begin
         s <= n;
      end
   end

   //------------------------------------------------------------
   // submodules
   //------------------------------------------------------------
   // bus master reading descriptors, two words per entry
   rdqf_ahb_fetch u_fetch (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .start     (fetchGo),
      .startAddr (s.cur),
      .beats     ({fetchN, 1'h0}),
      .mHready   (mHready),
      .mHrdata   (mHrdata),
      .mHaddr    (mHaddr),
      .mHtrans   (mHtrans),
      .mHburst   (mHburst),
      .mHsize    (mHsize),
      .mHwrite   (mHwrite),
      .busy      (mBusy),
      .beatValid (beatValid),
      .beatData  (beatData)
   );

   // local copies of fetched descriptors
   rdqf_desc_store u_store (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .push      (push),
      .pushData  ({beatData, s.word0}),
      .pop       (pop),
      .headValid (headValid),
      .headData  (headData),
      .level     (level)
   );

   //------------------------------------------------------------
   // outputs, all from flip-flops
   //------------------------------------------------------------
   assign hreadyout = s.ready;
   assign hresp     = s.resp;
   assign hrdata    = s.rdata;
   assign descValid = s.outValid;
   assign descAddr  = s.outAddr;
   assign descLen   = s.outLen;
   assign descTag   = s.outTag;
   assign descCont  = s.outCont;
   assign activeTag = s.activeTag;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence enqWriteSeq;
      s.sWrite && s.sAddr == REG_ENQ && !fetchGo;
   endsequence
   sequence fetchOnlySeq;
      fetchGo && !(s.sWrite && s.sAddr == REG_ENQ);
   endsequence
   sequence enqReadSeq;
      aPhase && !hwrite && haddr[7:0] == REG_ENQ && !s.sWrite && !fetchGo;
   endsequence

   enq_add_a: assert property (enqWriteSeq |=> s.avail == $past(s.avail) + {8'h00, $past(hwdata[7:0])})
      else $error("enqueue write not added");
   fetch_sub_a: assert property (fetchOnlySeq |=> s.avail == $past(s.avail) - {14'h0, $past(fetchN)})
      else $error("fetched count not subtracted");
   enq_read_a: assert property (enqReadSeq |=> hrdata == {16'h0, $past(s.avail)})
      else $error("enqueue read wrong total");
   // watched on the bus itself: an empty count never opens a new burst
   fetch_stall_a: assert property (s.avail == RST_COUNT && !mBusy |=> mHtrans != HTRANS_NONSEQ)
      else $error("fetch with empty count");
   zero_skip_a: assert property (descValid |-> descLen != 16'h0)
      else $error("zero-length buffer offered");
   cont_drop_a: assert property (contDrop |=> s.dropCnt == $past(s.dropCnt) + 16'h1)
      else $error("continuation buffer not discarded");
   // a take aimed at a continuation buffer with no frame open must not switch buffers
   cont_start_a: assert property (descValid && descCont && !frameOpen && descTake |=> activeTag == $past(activeTag))
      else $error("continuation buffer started a frame");
   tag_keep_a: assert property (takeOk |=> activeTag == $past(descTag))
      else $error("buffer tag not kept");
   ptr_wrap_a: assert property (push && !s.sWrite && (s.cur + DESC_BYTES >= s.base + s.qLen)
      |=> s.cur == $past(s.base))
      else $error("pointer did not wrap");
   burst_pair_a: assert property (fetchGo && fetchN == 2'h2 |=> mHtrans == HTRANS_NONSEQ ##1
      (mHtrans == HTRANS_SEQ || !mHready))
      else $error("two-entry fetch not a burst");
endmodule // rdqf_rx_desc_fetch
`default_nettype wire

//--- verif/rdqf_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module rdqf_mem_model import rdqf_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [31:0] mHaddr,
   input  wire logic [1:0]  mHtrans,
   output logic             mHready,
   output logic      [31:0] mHrdata
);
   logic [31:0] mem [0:7]; // ring of four descriptors at 0x100
   logic        pend;      // data phase open
   logic        waitOn;    // one wait state inserted
   logic [4:0]  addrQ;     // latched word address
   logic [31:0] cyc;       // cycle count, inverted for the idle bus pattern
   // pointer, then {cont, tag, len}; d1 empty, d2 continuation only
   initial mem = '{32'h2000, 32'h00110040, 32'h3000, 32'h00220000,
                   32'h4000, 32'h80330080, 32'h5000, 32'h00440100};
   // accept a beat, sometimes stall it one cycle so the master must hold
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend   <= 1'b0;
         waitOn <= 1'b0;
         cyc    <= 32'h0;
      end else begin
         cyc <= cyc + 32'h1;
         if (mHready) begin
            pend   <= mHtrans[1];
            addrQ  <= mHaddr[4:0];
            waitOn <= mHtrans[1] & cyc[1];
         end else begin
            waitOn <= 1'b0;
         end
      end
   end
   assign mHready = !(pend && waitOn);
   // outside a data phase the bus shows a changing pattern, never old data
   assign mHrdata = (pend && !waitOn) ? mem[addrQ[4:2]] : ~cyc;
endmodule // rdqf_mem_model
`default_nettype wire

//--- verif/rx_descriptor_queue_fetch_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rx_descriptor_queue_fetch_bench import rdqf_pkg::*; ;
   logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, frameOpen = 0, descTake = 0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   logic [1:0]  htrans = HTRANS_IDLE;
   logic hreadyout, hresp, descValid, descCont, mHwrite, mHready;
   logic [31:0] hrdata, mHaddr, mHrdata, descAddr;
   logic [1:0]  mHtrans;
   logic [2:0]  mHburst, mHsize;
   logic [15:0] descLen;
   logic [14:0] descTag, activeTag;
   int n_errors = 0, n_tests = 0, cycles = 0, i, w;
   // expected offers: frameOpen, address, length, tag
   logic [63:0] rows [0:5] = '{{16'h0,32'h2000,16'h40}, {16'h0,32'h5000,16'h100},
      {16'h1,32'h2000,16'h40}, {16'h1,32'h4000,16'h80}, {16'h1,32'h5000,16'h100},
      {16'h1,32'h2000,16'h40}};
   logic [14:0] tags [0:5] = '{15'h11, 15'h44, 15'h11, 15'h33, 15'h44, 15'h11};
   always #5 mclk = ~mclk;
   rdqf_rx_desc_fetch dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .mHaddr(mHaddr), .mHtrans(mHtrans), .mHburst(mHburst),
      .mHsize(mHsize), .mHwrite(mHwrite), .mHready(mHready), .mHrdata(mHrdata), .frameOpen(frameOpen),
      .descTake(descTake), .descValid(descValid), .descAddr(descAddr), .descLen(descLen),
      .descTag(descTag), .descCont(descCont), .activeTag(activeTag));
   rdqf_mem_model mem (.mclk(mclk), .rst_n(rst_n), .mHaddr(mHaddr), .mHtrans(mHtrans),
      .mHready(mHready), .mHrdata(mHrdata));
   //----------------------------------------------------------
   // shared helpers
   //----------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one single AHB-Lite word transfer, held until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop;
      end
   end
   //----------------------------------------------------------
   // main sequence
   //----------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      bus(0, REG_ENQ, 0);
      chk("count after reset", 32'h0, q);
      chk("offer after reset", 32'h0, {31'h0, descValid});
      bus(1, REG_BASE, 32'h100);
      bus(1, REG_LEN, 32'h20);
      bus(1, REG_CUR, 32'h100);
      bus(1, REG_ENQ, 32'h5);
      bus(1, REG_ENQ, 32'h4);
      bus(0, REG_ENQ, 0);
      chk("enqueue sum", 32'h9, {16'h0, q[15:0]});
      bus(0, 8'h1c, 0);
      chk("unmapped read", 32'h0, q);
      bus(1, REG_CTRL, 32'h1);
      // nine fetches: empty slot skipped, continuation dropped once
      for (i = 0; i < 6; i++) begin
         frameOpen <= rows[i][48];
         // a continuation buffer shown with no frame open is discarded, so pass it by
         w = 0;
         do begin
            @(posedge mclk);
            w++;
         end while ((descValid !== 1'b1 || (descCont === 1'b1 && frameOpen === 1'b0)) && w < 400);
         chk("offer addr", rows[i][47:16], descAddr);
         chk("offer len", {16'h0, rows[i][15:0]}, {16'h0, descLen});
         chk("offer tag", {17'h0, tags[i]}, {17'h0, descTag});
         chk("offer cont", {31'h0, i == 3}, {31'h0, descCont});
         descTake <= 1'b1;
         @(posedge mclk);
         descTake <= 1'b0;
         @(posedge mclk);
         chk("active tag", {17'h0, tags[i]}, {17'h0, activeTag});
      end
      repeat (40) @(posedge mclk);
      chk("nothing more offered", 32'h0, {31'h0, descValid});
      bus(0, REG_ENQ, 0);
      chk("count drained", 32'h0, {16'h0, q[15:0]});
      bus(0, REG_DROP, 0);
      chk("drop count", 32'h1, q);
      bus(0, REG_CUR, 0);
      chk("wrapped pointer", 32'h108, q);
      chk("bus master read", 32'h0, {31'h0, mHwrite});
      chk("burst kind", {29'h0, HBURST_INCR}, {29'h0, mHburst});
      bus(0, REG_STAT, 0);
      chk("idle status", 32'h0, q);
      // take held high with no frame open: continuation buffer dropped, next one taken
      frameOpen <= 1'b0;
      descTake  <= 1'b1;
      bus(1, REG_ENQ, 32'h3);
      repeat (60) @(posedge mclk);
      chk("tag after held take", {17'h0, 15'h44}, {17'h0, activeTag});
      descTake <= 1'b0;
      bus(0, REG_DROP, 0);
      chk("second drop", 32'h2, q);
      // reset in mid-run: everything back to its idle values
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk("reset hreadyout", 32'h1, {31'h0, hreadyout});
      chk("reset hresp", 32'h0, {31'h0, hresp});
      chk("reset htrans", {30'h0, HTRANS_IDLE}, {30'h0, mHtrans});
      chk("reset maddr", 32'h0, mHaddr);
      chk("reset msize", {29'h0, HSIZE_WORD}, {29'h0, mHsize});
      chk("reset offer", 32'h0, {31'h0, descValid});
      chk("reset tag", 32'h0, {17'h0, activeTag});
      bus(0, REG_CUR, 0);
      chk("pointer after reset", 32'h0, q);
      bus(0, REG_DROP, 0);
      chk("drops after reset", 32'h0, q);
      report_and_stop;
   end
endmodule // rx_descriptor_queue_fetch_bench
`default_nettype wire
